// ### logic/aiv_map.svh
// Register indices, field positions, reset values and bus constants of the converter interrupt unit.
`ifndef AIV_MAP_SVH
`define AIV_MAP_SVH

`define AIV_ADDR_W        12
`define AIV_IDX_W         10
`define AIV_IDX_STATUS    10'h0F0
`define AIV_IDX_MASK      10'h0F1
`define AIV_IDX_GO        10'h0F2
`define AIV_IDX_CMP_RES   10'h0F3
`define AIV_IDX_THR_FIRST 10'h0F4
`define AIV_IDX_THR_LAST  10'h0FB
`define AIV_IDX_CTRL      10'h0FE
`define AIV_IDX_VECTOR    10'h0FF

`define AIV_CTRL_DONE_BIT    7
`define AIV_CTRL_ALARM_BIT   6
`define AIV_CTRL_DONE_EN_BIT 5
`define AIV_CTRL_ALARM_EN_BIT 4
`define AIV_CTRL_PRIO_MSB    2
`define AIV_VEC_BASE_MSB     7
`define AIV_VEC_BASE_LSB     2
`define AIV_VEC_WSEL_BIT     1

`define AIV_EVT_DONE_BIT  0
`define AIV_EVT_ALARM_BIT 1
`define AIV_GO_RUN_BIT    0
`define AIV_GO_CONT_BIT   1

`define AIV_CTRL_RESET    8'h07
`define AIV_VEC_BASE_RST  6'h00
`define AIV_WSEL_RESET    1'b1
`define AIV_THR_HI_RESET  8'hFF
`define AIV_THR_LO_RESET  8'h00

`define AIV_NUM_CHAN      2
`define AIV_NUM_THR       8
`define AIV_RES_W         10

`endif

// ### logic/aiv_pkg.sv
// Types shared by the converter interrupt unit and its window comparator.
package aiv_pkg;

  typedef struct packed {
    logic       conv_done_flag;
    logic       window_alarm_flag;
    logic       conv_done_irq_en;
    logic       window_alarm_irq_en;
    logic [2:0] irq_priority_level;
  } aiv_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       chan_a;
    logic       chan_b;
    logic [9:0] value;
  } aiv_sample_t;

  typedef struct packed {
    logic       irq_req;
    logic [2:0] irq_priority_level;
    logic [7:0] irq_vector;
  } aiv_core_req_t;

  typedef enum logic [2:0] {
    AIV_IDLE        = 3'b001,
    AIV_SERVE_ALARM = 3'b010,
    AIV_SERVE_DONE  = 3'b100
  } aiv_serve_t;

endpackage

// ### logic/aiv_window_cmp.sv
// Window comparator of one monitored channel against its upper and lower threshold.
`timescale 1ns/1ps
module aiv_window_cmp
  import aiv_pkg::*;
(
  input  wire logic [9:0] value,
  input  wire logic [9:0] upper,
  input  wire logic [9:0] lower,
  input  wire logic       hit,
  output logic            beyond
);

  assign beyond = hit && ((value > upper) || (value < lower));

endmodule // aiv_window_cmp

// ### logic/aiv_irq_unit.sv
// Converter interrupt unit: flags, enables, priority, vector and window alarm logic on APB.
//
// Operation
// - Group completion sets conversion-done flag.
// - Software writing flag one raises request.
// - Out-of-window result sets window alarm flag.
// - Channels A and B use their threshold pairs.
// - Compare result register records exceeding channels.
// - Done enable gates conversion-done request.
// - Alarm enable gates window alarm request.
// - Three-bit priority goes with both requests.
// - Word select shows source: alarm zero, done one.
// - Simultaneous requests serve alarm, done waits.
// - Vector bit zero always reads zero.
// - Control register resets to seven.
// - Single-shot end clears go bit, marks completion.
`timescale 1ns/1ps
`include "aiv_map.svh"
module aiv_irq_unit
  import aiv_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`AIV_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sequence_end,
  input  wire aiv_sample_t            sample,
  output logic                        conversion_go_bit,
  output logic                        continuous_mode,
  output aiv_core_req_t               core_req,
  output logic                        aiv_irq
);

  logic [`AIV_IDX_W-1:0] idx;
  logic                  aligned;
  logic                  mapped;
  logic                  setup_phase;
  logic                  wr_en;
  logic [7:0]            wbyte;
  logic                  lane0;

  aiv_ctrl_t             ctrl_reg;
  logic [5:0]            vec_base_reg;
  logic                  source_word_select_reg;
  logic [1:0]            status_reg;
  logic [1:0]            mask_reg;
  logic                  go_reg;
  logic                  cont_reg;
  logic [1:0]            compare_result_reg;
  logic [7:0]            thr_reg [0:`AIV_NUM_THR-1];
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;

  aiv_serve_t            serve_reg;
  aiv_serve_t            serve_next;

  logic                  alarm_req;
  logic                  done_req;
  logic                  group_done;
  logic [`AIV_NUM_CHAN-1:0] chan_beyond;
  logic                  alarm_event;
  logic [1:0]            hw_events;
  logic                  ctrl_wr;
  logic                  vec_wr;
  logic                  status_wr;
  logic                  mask_wr;
  logic                  go_wr;
  logic                  cmp_wr;

  logic [9:0]            thr_upper [0:`AIV_NUM_CHAN-1];
  logic [9:0]            thr_lower [0:`AIV_NUM_CHAN-1];

  // Reset value of the control register as read, reserved bit three included.
  localparam logic [7:0] CTRL_RST = `AIV_CTRL_RESET;

  // Bus decode: one aligned word per register, zero wait states.
  assign idx         = paddr[`AIV_ADDR_W-1:2];
  assign aligned     = (paddr[1:0] == 2'h0);
  assign setup_phase = psel && !penable;
  assign mapped      = aligned && ((idx == `AIV_IDX_CTRL) || (idx == `AIV_IDX_VECTOR) ||
                       (idx == `AIV_IDX_STATUS) || (idx == `AIV_IDX_MASK) ||
                       (idx == `AIV_IDX_GO) || (idx == `AIV_IDX_CMP_RES) ||
                       ((idx >= `AIV_IDX_THR_FIRST) && (idx <= `AIV_IDX_THR_LAST)));
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;
  assign lane0       = pstrb[0];
  assign wr_en       = psel && penable && pwrite && mapped && lane0;
  assign wbyte       = pwdata[7:0];

  assign ctrl_wr   = wr_en && (idx == `AIV_IDX_CTRL);
  assign vec_wr    = wr_en && (idx == `AIV_IDX_VECTOR);
  assign status_wr = wr_en && (idx == `AIV_IDX_STATUS);
  assign mask_wr   = wr_en && (idx == `AIV_IDX_MASK);
  assign go_wr     = wr_en && (idx == `AIV_IDX_GO);
  assign cmp_wr    = wr_en && (idx == `AIV_IDX_CMP_RES);

  // A finished group while the go bit is set, in either mode; in single-shot mode the go bit also drops then.
  assign group_done = sequence_end && go_reg;

  // Threshold pairs: high byte holds bits 9:2, the next register bits 1:0 in its top two bits.
  assign thr_upper[0] = {thr_reg[0], thr_reg[1][7:6]};
  assign thr_lower[0] = {thr_reg[4], thr_reg[5][7:6]};
  assign thr_upper[1] = {thr_reg[2], thr_reg[3][7:6]};
  assign thr_lower[1] = {thr_reg[6], thr_reg[7][7:6]};

  // One window comparator per monitored channel.
  for (genvar c = 0; c < `AIV_NUM_CHAN; c++) begin : g_chan
    aiv_window_cmp u_cmp (
      .value  (sample.value),
      .upper  (thr_upper[c]),
      .lower  (thr_lower[c]),
      .hit    (sample.valid && ((c == 0) ? sample.chan_a : sample.chan_b)),
      .beyond (chan_beyond[c])
    );
  end

  assign alarm_event = |chan_beyond;
  assign hw_events   = {alarm_event, group_done};

  // Requests toward the core exist only while flag and enable are both set.
  assign alarm_req = ctrl_reg.window_alarm_flag && ctrl_reg.window_alarm_irq_en;
  assign done_req  = ctrl_reg.conv_done_flag && ctrl_reg.conv_done_irq_en;

  // Control register: hardware set wins over a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= aiv_ctrl_t'({CTRL_RST[7:4], CTRL_RST[2:0]});
    end else begin
      if (ctrl_wr) begin
        ctrl_reg.conv_done_flag      <= wbyte[`AIV_CTRL_DONE_BIT];
        ctrl_reg.window_alarm_flag   <= wbyte[`AIV_CTRL_ALARM_BIT];
        ctrl_reg.conv_done_irq_en    <= wbyte[`AIV_CTRL_DONE_EN_BIT];
        ctrl_reg.window_alarm_irq_en <= wbyte[`AIV_CTRL_ALARM_EN_BIT];
        ctrl_reg.irq_priority_level  <= wbyte[`AIV_CTRL_PRIO_MSB:0];
      end
      if (group_done) begin
        ctrl_reg.conv_done_flag <= 1'b1;
      end
      if (alarm_event) begin
        ctrl_reg.window_alarm_flag <= 1'b1;
      end
    end
  end

  // Vector base is software written; its low bit is never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_base_reg <= `AIV_VEC_BASE_RST;
    end else if (vec_wr) begin
      vec_base_reg <= wbyte[`AIV_VEC_BASE_MSB:`AIV_VEC_BASE_LSB];
    end
  end

  // Service sequencer: the alarm always takes precedence, a done request waits.
  always_comb begin
    serve_next = serve_reg;
    unique case (serve_reg)
      AIV_IDLE: begin
        if (alarm_req) begin
          serve_next = AIV_SERVE_ALARM;
        end else if (done_req) begin
          serve_next = AIV_SERVE_DONE;
        end
      end
      AIV_SERVE_ALARM: begin
        if (!alarm_req) begin
          serve_next = done_req ? AIV_SERVE_DONE : AIV_IDLE;
        end
      end
      AIV_SERVE_DONE: begin
        if (alarm_req) begin
          serve_next = AIV_SERVE_ALARM;
        end else if (!done_req) begin
          serve_next = AIV_IDLE;
        end
      end
      default: begin
        serve_next = AIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serve_reg <= AIV_IDLE;
    end else begin
      serve_reg <= serve_next;
    end
  end

  // Word select follows the source chosen for service.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_word_select_reg <= `AIV_WSEL_RESET;
    end else if (serve_next == AIV_SERVE_ALARM) begin
      source_word_select_reg <= 1'b0;
    end else if (serve_next == AIV_SERVE_DONE) begin
      source_word_select_reg <= 1'b1;
    end
  end

  // Sticky event status, cleared by writing one; a new event wins over the clear.
  for (genvar e = 0; e < 2; e++) begin : g_evt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        status_reg[e] <= 1'b0;
      end else if (hw_events[e]) begin
        status_reg[e] <= 1'b1;
      end else if (status_wr && wbyte[e]) begin
        status_reg[e] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 2'h0;
    end else if (mask_wr) begin
      mask_reg <= wbyte[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aiv_irq <= 1'b0;
    end else begin
      aiv_irq <= |(status_next_and_mask(status_reg, hw_events, status_wr, wbyte[1:0], mask_reg));
    end
  end

  function automatic logic [1:0] status_next_and_mask(
    input logic [1:0] st_now,
    input logic [1:0] ev,
    input logic       clr_wr,
    input logic [1:0] clr,
    input logic [1:0] msk
  );
    logic [1:0] nxt;
    nxt = ev | (st_now & ~(clr_wr ? clr : 2'h0));
    return nxt & msk;
  endfunction

  // Go bit and mode: the go bit drops by itself at the end of a single-shot group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_reg   <= 1'b0;
      cont_reg <= 1'b0;
    end else begin
      if (group_done && !cont_reg) begin
        go_reg <= 1'b0;
      end
      if (go_wr) begin
        go_reg   <= wbyte[`AIV_GO_RUN_BIT];
        cont_reg <= wbyte[`AIV_GO_CONT_BIT];
      end
    end
  end

  // Compare result: which channel left its window, cleared by writing one.
  for (genvar c = 0; c < `AIV_NUM_CHAN; c++) begin : g_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        compare_result_reg[c] <= 1'b0;
      end else if (chan_beyond[c]) begin
        compare_result_reg[c] <= 1'b1;
      end else if (cmp_wr && wbyte[c]) begin
        compare_result_reg[c] <= 1'b0;
      end
    end
  end

  // Threshold registers: upper bytes reset high, lower bytes low, so no alarm at start.
  for (genvar t = 0; t < `AIV_NUM_THR; t++) begin : g_thr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        thr_reg[t] <= (t < 4) ? `AIV_THR_HI_RESET : `AIV_THR_LO_RESET;
      end else if (wr_en && (idx == (`AIV_IDX_THR_FIRST + 10'(t)))) begin
        thr_reg[t] <= wbyte;
      end
    end
  end

  // Read data is captured in the setup cycle and presented in the access cycle.
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (aligned) begin
      if (idx == `AIV_IDX_CTRL) begin
        prdata_next[7:0] = {ctrl_reg.conv_done_flag, ctrl_reg.window_alarm_flag,
                            ctrl_reg.conv_done_irq_en, ctrl_reg.window_alarm_irq_en,
                            1'b0, ctrl_reg.irq_priority_level};
      end else if (idx == `AIV_IDX_VECTOR) begin
        prdata_next[7:0] = {vec_base_reg, source_word_select_reg, 1'b0};
      end else if (idx == `AIV_IDX_STATUS) begin
        prdata_next[1:0] = status_reg;
      end else if (idx == `AIV_IDX_MASK) begin
        prdata_next[1:0] = mask_reg;
      end else if (idx == `AIV_IDX_GO) begin
        prdata_next[1:0] = {cont_reg, go_reg};
      end else if (idx == `AIV_IDX_CMP_RES) begin
        prdata_next[1:0] = compare_result_reg;
      end else if ((idx >= `AIV_IDX_THR_FIRST) && (idx <= `AIV_IDX_THR_LAST)) begin
        prdata_next[7:0] = thr_reg[3'(idx - `AIV_IDX_THR_FIRST)];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // Request toward the core with priority and vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= '0;
    end else begin
      // The request follows the gated flags one cycle later.
      core_req.irq_req            <= alarm_req || done_req;
      core_req.irq_priority_level <= ctrl_reg.irq_priority_level;
      core_req.irq_vector         <= {vec_base_reg, source_word_select_reg, 1'b0};
    end
  end

  assign conversion_go_bit = go_reg;
  assign continuous_mode   = cont_reg;

endmodule // aiv_irq_unit

// ### tb/aiv_irq_props.sv
// Property checker for the converter interrupt unit ports.
`timescale 1ns/1ps
`include "aiv_map.svh"
module aiv_irq_props
  import aiv_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`AIV_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   sequence_end,
  input wire aiv_sample_t            sample,
  input wire logic                   conversion_go_bit,
  input wire logic                   continuous_mode,
  input wire aiv_core_req_t          core_req,
  input wire logic                   aiv_irq
);
  localparam logic [11:0] A_CTRL = 12'h3F8;
  localparam logic [11:0] A_VEC = 12'h3FC;
  logic acc;
  logic cwr;
  assign acc = psel && penable;
  assign cwr = acc && pwrite && pstrb[0] && paddr == A_CTRL && !sample.valid && !sequence_end;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sw_done_req: assert property (cwr && pwdata[7:4] == 4'hA |-> ##[2:4]
    (core_req.irq_req && core_req.irq_vector[1])) else $error("done request missing");
  a_sw_alarm_req: assert property (cwr && pwdata[7:4] == 4'h5 |-> ##[2:4]
    (core_req.irq_req && !core_req.irq_vector[1])) else $error("alarm request missing");
  a_alarm_wins: assert property (cwr && pwdata[7:4] == 4'hF |-> ##[2:4]
    (core_req.irq_req && !core_req.irq_vector[1])) else $error("alarm not served first");
  a_masked_quiet: assert property (cwr && pwdata[5:4] == 2'b00 |-> ##3
    !core_req.irq_req) else $error("request while both enables clear");
  a_prio_follows: assert property (cwr |-> ##3
    core_req.irq_priority_level == $past(pwdata[2:0], 3)) else $error("priority mismatch");
  a_vec_lsb_zero: assert property (core_req.irq_vector[0] == 1'b0)
    else $error("vector bit zero set");
  a_read_lsb_zero: assert property (acc && !pwrite && paddr == A_VEC |->
    prdata[0] == 1'b0 && prdata[31:8] == 24'h000000) else $error("vector read bits");
  a_single_go_clear: assert property (sequence_end && conversion_go_bit &&
    !continuous_mode |=> !conversion_go_bit) else $error("go bit not cleared");
  a_cont_go_kept: assert property (sequence_end && conversion_go_bit &&
    continuous_mode && !(psel && penable && pwrite) |=> conversion_go_bit)
    else $error("go bit dropped in continuous mode");
  a_unmapped_err: assert property (acc && paddr == 12'h000 |-> pslverr)
    else $error("unmapped access without error");
  cover property (cwr && pwdata[7:4] == 4'hF);
  cover property (sequence_end && conversion_go_bit);
  cover property (sample.valid ##1 !sample.valid);
endmodule // aiv_irq_props

bind aiv_irq_unit aiv_irq_props chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sequence_end(sequence_end),
  .sample(sample), .conversion_go_bit(conversion_go_bit),
  .continuous_mode(continuous_mode), .core_req(core_req), .aiv_irq(aiv_irq));

// ### tb/aiv_core_model.sv
// Behavioural model of the core interrupt logic that takes converter requests.
`timescale 1ns/1ps
module aiv_core_model
  import aiv_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire aiv_core_req_t core_req,
  output logic [7:0]         served_vec
);
  // The core records the vector of the request in served_vec while a request stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      served_vec <= 8'h00;
    end else if (core_req.irq_req) begin
      served_vec <= core_req.irq_vector;
    end
  end
endmodule // aiv_core_model

// ### tb/testbench.sv
// Self-checking testbench for the converter interrupt unit.
`timescale 1ns/1ps
module testbench
  import aiv_pkg::*;
;
  localparam logic [11:0] A_STAT = 12'h3C0, A_MASK = 12'h3C4, A_GO = 12'h3C8, A_CMP = 12'h3CC;
  localparam logic [11:0] A_THR = 12'h3D0, A_CTRL = 12'h3F8, A_VEC = 12'h3FC;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [3:0]    pstrb = 4'hF;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          sequence_end = 1'b0;
  aiv_sample_t   sample = '0;
  logic          go_bit;
  logic          cont;
  aiv_core_req_t core_req;
  logic          aiv_irq;
  logic [7:0]    m_vec;
  logic [31:0]   rd;
  logic          err;
  int            n_errors = 0;
  int            checks = 0;

  aiv_irq_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sequence_end(sequence_end), .sample(sample),
    .conversion_go_bit(go_bit), .continuous_mode(cont), .core_req(core_req),
    .aiv_irq(aiv_irq));
  aiv_core_model core_m (.pclk(pclk), .presetn(presetn), .core_req(core_req),
    .served_vec(m_vec));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    apb(1'b0, A_CTRL, 8'h00);
    chk("ctrl reset", 8'h07, rd[7:0]);
    apb(1'b0, A_VEC, 8'h00);
    chk("vector reset", 8'h02, rd[7:0]);
    apb(1'b0, 12'h000, 8'h00);
    chk("unmapped error", 8'h01, {7'h00, err});
    $display("test reset done");
  endtask

  task automatic t_conv();
    apb(1'b1, A_GO, 8'h01);
    cyc(1);
    chk("go set", 8'h01, {7'h00, go_bit});
    sequence_end <= 1'b1;
    @(posedge pclk);
    sequence_end <= 1'b0;
    cyc(2);
    chk("go cleared", 8'h00, {7'h00, go_bit});
    apb(1'b0, A_CTRL, 8'h00);
    chk("done flag", 8'h87, rd[7:0]);
    apb(1'b0, A_STAT, 8'h00);
    chk("status", 8'h01, rd[7:0]);
    apb(1'b1, A_MASK, 8'h01);
    cyc(2);
    chk("irq raised", 8'h01, {7'h00, aiv_irq});
    apb(1'b1, A_MASK, 8'h00);
    cyc(2);
    chk("irq masked", 8'h00, {7'h00, aiv_irq});
    apb(1'b1, A_MASK, 8'h01);
    apb(1'b1, A_STAT, 8'h01);
    cyc(2);
    chk("irq cleared", 8'h00, {7'h00, aiv_irq});
    apb(1'b1, A_GO, 8'h03);
    cyc(1);
    chk("continuous go", 8'h03, {6'h00, cont, go_bit});
    sequence_end <= 1'b1;
    @(posedge pclk);
    sequence_end <= 1'b0;
    cyc(2);
    chk("go kept", 8'h01, {7'h00, go_bit});
    chk("irq again", 8'h01, {7'h00, aiv_irq});
    apb(1'b1, A_GO, 8'h00);
    apb(1'b1, A_STAT, 8'h01);
    cyc(2);
    chk("irq cleared again", 8'h00, {7'h00, aiv_irq});
    apb(1'b1, A_CTRL, 8'h07);
    $display("test conversion done");
  endtask

  task automatic t_win();
    apb(1'b1, A_THR, 8'h80);
    apb(1'b1, A_THR + 12'h004, 8'h00);
    @(posedge pclk);
    sample <= '{1'b1, 1'b1, 1'b0, 10'h300};
    @(posedge pclk);
    sample <= '0;
    cyc(2);
    apb(1'b0, A_CTRL, 8'h00);
    chk("alarm flag", 8'h47, rd[7:0]);
    apb(1'b0, A_CMP, 8'h00);
    chk("compare a", 8'h01, rd[7:0]);
    apb(1'b1, A_CMP, 8'h03);
    @(posedge pclk);
    sample <= '{1'b1, 1'b0, 1'b1, 10'h300};
    @(posedge pclk);
    sample <= '0;
    cyc(2);
    apb(1'b0, A_CMP, 8'h00);
    chk("compare b", 8'h00, rd[7:0]);
    apb(1'b1, A_STAT, 8'h02);
    apb(1'b1, A_CTRL, 8'h07);
    $display("test window done");
  endtask

  task automatic t_sw();
    logic [9:0] tab [7] = '{10'h28F, 10'h14E, 10'h20C, 10'h10C, 10'h02C, 10'h3D6, 10'h2D7};
    apb(1'b1, A_VEC, 8'hFF);
    apb(1'b0, A_VEC, 8'h00);
    chk("vector read", 8'hFC, {rd[7:2], 1'b0, rd[0]});
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, A_CTRL, tab[i][9:2]);
      cyc(4);
      chk("request", {7'h00, tab[i][1]}, {7'h00, core_req.irq_req});
      chk("priority", {5'h00, tab[i][4:2]}, {5'h00, core_req.irq_priority_level});
      if (tab[i][1]) begin
        chk("word select", {7'h00, tab[i][0]}, {7'h00, core_req.irq_vector[1]});
      end
    end
    chk("served vector", 8'hFE, m_vec);
    apb(1'b1, A_CTRL, 8'h07);
    cyc(4);
    chk("request off", 8'h00, {7'h00, core_req.irq_req});
    $display("test software done");
  endtask

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_conv();
    t_win();
    t_sw();
    complete_run();
  end
endmodule // testbench
